// ---- logic/wec_event_capture.sv ----
`timescale 1ns/10ps
module wec_event_capture #(
  parameter int unsigned EVENT_DELAY = wec_pkg::EVENT_DELAY_CYC
) (
  input  wire logic                  i_mclk,
  input  wire logic                  i_resetn,
  input  wire logic                  i_wake_pin,
  input  wec_pkg::wec_src_t          i_src,
  input  wec_pkg::wec_cond_t         i_cond,
  input  wire logic                  i_wdog_window_mode,
  input  wire logic                  i_rstn_low,
  input  wec_pkg::wec_reg_req_t      i_reg,
  output logic [7:0]                 o_rd_data,
  output logic                       o_rxd_low,
  output logic                       o_trx_supply_fault_status,
  output logic                       o_sleep_allowed,
  output logic                       o_wake_from_sleep,
  output logic                       o_system_reset
);
  import wec_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]     sys_stat, sup_stat, trx_stat, wake_stat;
  logic [7:0]     sys_en, sup_en, trx_en, wake_en;
  logic           supply_fault, power_on_pend;
  logic [7:0]     rd_data;
  wec_rxd_state_t rxd_state;
  logic [7:0]     next_sys_stat, next_sup_stat, next_trx_stat, next_wake_stat;
  logic [7:0]     next_sys_en, next_sup_en, next_trx_en, next_wake_en;
  logic           next_supply_fault, next_power_on_pend;
  logic [7:0]     next_rd_data;
  wec_rxd_state_t next_rxd_state;

  logic wake_level, wake_rise, wake_fall;
  logic in_sleep, in_normal, any_pend, any_clear, new_capture;
  logic timer_running, timer_expired;
  logic [7:0] sys_set, sup_set, trx_set, wake_set;
  logic [7:0] global_status;

  // write-one-to-clear decode, reused for every status register
  function automatic logic [7:0] w1c(input wec_reg_req_t req, input logic [6:0] addr,
                                     input logic [7:0] mask);
    w1c = (req.wr && req.addr == addr) ? (req.data & mask) : 8'h00;
  endfunction : w1c

  // ---------------------------------------------------------------
  // wake pin front end
  // ---------------------------------------------------------------
  wec_sync u_wake_sync (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_async  (i_wake_pin),
    .o_level  (wake_level),
    .o_rise   (wake_rise),
    .o_fall   (wake_fall)
  );

  // held-off interval after each clear
  wec_delay_timer #(
    .DELAY_CYC (EVENT_DELAY)
  ) u_delay (
    .i_mclk    (i_mclk),
    .i_resetn  (i_resetn),
    .i_start   (any_clear),
    .i_stop    (i_rstn_low),
    .o_running (timer_running),
    .o_expired (timer_expired)
  );

  assign in_sleep  = (i_cond.device_mode_code == DEV_MODE_SLEEP);
  assign in_normal = (i_cond.device_mode_code == DEV_MODE_NORMAL);

  // ---------------------------------------------------------------
  // event qualification
  // ---------------------------------------------------------------
  always_comb begin
    sys_set  = 8'h00;
    sup_set  = 8'h00;
    trx_set  = 8'h00;
    wake_set = 8'h00;
    sys_set[BIT_SYS_POWER_ON] = power_on_pend;
    sys_set[BIT_SYS_WATCHDOG] = i_src.watchdog_fail;
    sys_set[BIT_SYS_OVERTEMP] = i_src.overtemp & sys_en[BIT_SYS_OVERTEMP] & ~in_sleep;
    sys_set[BIT_SYS_SERIAL]   = i_src.serial_fail & sys_en[BIT_SYS_SERIAL] & ~in_sleep;
    sup_set[BIT_SUP_SENS_OV]  = i_src.sensor_over & sup_en[BIT_SUP_SENS_OV];
    sup_set[BIT_SUP_SENS_UV]  = i_src.sensor_under & sup_en[BIT_SUP_SENS_UV];
    // threshold selection has no bearing on this capture
    sup_set[BIT_SUP_MCU_UV]   = i_src.mcu_under & sup_en[BIT_SUP_MCU_UV] & ~in_sleep;
    trx_set[BIT_TRX_FRAME]    = i_src.frame_error;
    trx_set[BIT_TRX_SILENCE]  = i_src.bus_silence & trx_en[BIT_TRX_SILENCE]
                              & i_cond.bus_was_active;
    trx_set[BIT_TRX_FAIL]     = trx_en[BIT_TRX_FAIL]
                              & ((i_src.trx_supply_low
                                  & (i_cond.transceiver_mode_ctrl == TRX_MODE_FAIL_DETECT))
                                 | (i_src.txd_clamped & ~in_sleep));
    trx_set[BIT_TRX_WAKEUP]   = i_src.bus_wakeup & trx_en[BIT_TRX_WAKEUP]
                              & i_cond.trx_offline;
    wake_set[BIT_WAKE_RISE]   = wake_rise & wake_en[BIT_WAKE_RISE];
    wake_set[BIT_WAKE_FALL]   = wake_fall & wake_en[BIT_WAKE_FALL];
  end

  // ---------------------------------------------------------------
  // status and enable registers
  // ---------------------------------------------------------------
  // set wins over a clear in the same cycle, so no event is dropped
  always_comb begin
    next_sys_stat  = (sys_stat  & ~w1c(i_reg, ADDR_SYSTEM,  MASK_SYS))  | sys_set;
    next_sup_stat  = (sup_stat  & ~w1c(i_reg, ADDR_SUPPLY,  MASK_SUP))  | sup_set;
    next_trx_stat  = (trx_stat  & ~w1c(i_reg, ADDR_TRX,     MASK_TRX))  | trx_set;
    next_wake_stat = (wake_stat & ~w1c(i_reg, ADDR_WAKEPIN, MASK_WAKE)) | wake_set;
    next_power_on_pend = 1'b0;        // one-shot after reset release
    next_supply_fault = supply_fault | (trx_set[BIT_TRX_FAIL] & i_src.trx_supply_low);
    if (i_reg.wr && i_reg.addr == ADDR_TRX && i_reg.data[BIT_TRX_FAIL]) begin
      next_supply_fault = trx_set[BIT_TRX_FAIL] & i_src.trx_supply_low;
    end
    next_sys_en  = sys_en;
    next_sup_en  = sup_en;
    next_trx_en  = trx_en;
    next_wake_en = wake_en;
    if (i_reg.wr) begin
      case (i_reg.addr)
        ADDR_SYS_EN:  next_sys_en  = i_reg.data & MASK_SYS;
        ADDR_SUP_EN:  next_sup_en  = i_reg.data & MASK_SUP;
        ADDR_TRX_EN:  next_trx_en  = i_reg.data & MASK_TRX;
        ADDR_WAKE_EN: next_wake_en = i_reg.data & MASK_WAKE;
        default:      next_sys_en  = sys_en;
      endcase
    end
  end

  // any write of a one to a set bit counts as a clear
  assign any_clear = |{sys_stat & w1c(i_reg, ADDR_SYSTEM, MASK_SYS),
                       sup_stat & w1c(i_reg, ADDR_SUPPLY, MASK_SUP),
                       trx_stat & w1c(i_reg, ADDR_TRX, MASK_TRX),
                       wake_stat & w1c(i_reg, ADDR_WAKEPIN, MASK_WAKE)};

  // enables cleared at power-on: all wake sources but watchdog failure, frame error and the power-on capture start disabled
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      sys_stat      <= RESET_BYTE;
      sup_stat      <= RESET_BYTE;
      trx_stat      <= RESET_BYTE;
      wake_stat     <= RESET_BYTE;
      sys_en        <= RESET_BYTE;
      sup_en        <= RESET_BYTE;
      trx_en        <= RESET_BYTE;
      wake_en       <= RESET_BYTE;
      supply_fault  <= 1'b0;
      power_on_pend <= 1'b1;
    end else begin
      sys_stat      <= next_sys_stat;
      sup_stat      <= next_sup_stat;
      trx_stat      <= next_trx_stat;
      wake_stat     <= next_wake_stat;
      sys_en        <= next_sys_en;
      sup_en        <= next_sup_en;
      trx_en        <= next_trx_en;
      wake_en       <= next_wake_en;
      supply_fault  <= next_supply_fault;
      power_on_pend <= next_power_on_pend;
    end
  end

  // ---------------------------------------------------------------
  // summaries and read path
  // ---------------------------------------------------------------
  always_comb begin
    global_status = 8'h00;
    global_status[BIT_GLB_WAKE]   = |wake_stat;
    global_status[BIT_GLB_TRX]    = |trx_stat;
    global_status[BIT_GLB_SUPPLY] = |sup_stat;
    global_status[BIT_GLB_SYSTEM] = |sys_stat;
  end
  assign any_pend    = |global_status;
  assign new_capture = |{sys_set, sup_set, trx_set, wake_set};

  // read data registered; unmapped addresses read zero
  always_comb begin
    next_rd_data = rd_data;
    if (i_reg.rd) begin
      case (i_reg.addr)
        ADDR_GLOBAL:   next_rd_data = global_status;
        ADDR_SYSTEM:   next_rd_data = sys_stat;
        ADDR_SUPPLY:   next_rd_data = sup_stat;
        ADDR_TRX:      next_rd_data = trx_stat;
        ADDR_WAKEPIN:  next_rd_data = wake_stat;
        ADDR_SYS_EN:   next_rd_data = sys_en;
        ADDR_SUP_EN:   next_rd_data = sup_en;
        ADDR_TRX_EN:   next_rd_data = trx_en;
        ADDR_WAKE_EN:  next_rd_data = wake_en;
        ADDR_WAKE_LVL: begin
          next_rd_data = 8'h00;
          // outside normal mode, level only meaningful with an edge enabled
          next_rd_data[BIT_WAKE_LEVEL] = wake_level & (in_normal | (|wake_en));
        end
        default:       next_rd_data = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // rxd signalling
  // ---------------------------------------------------------------
  always_comb begin
    next_rxd_state = rxd_state;
    case (rxd_state)
      WEC_IDLE: begin
        if (any_clear) begin
          next_rxd_state = WEC_HOLDOFF;
        end else if (any_pend || new_capture) begin
          next_rxd_state = WEC_SIGNAL;
        end
      end
      WEC_SIGNAL: begin
        if (any_clear) begin
          next_rxd_state = WEC_HOLDOFF;
        end
      end
      WEC_HOLDOFF: begin
        // events during holdoff only set bits; rxd waits for expiry or i_rstn_low
        // a clear landing on the expiry edge must restart the holdoff
        if (any_clear) begin
          next_rxd_state = WEC_HOLDOFF;
        end else if (i_rstn_low) begin
          next_rxd_state = any_pend ? WEC_SIGNAL : WEC_IDLE;
        end else if (timer_expired) begin
          next_rxd_state = any_pend ? WEC_SIGNAL : WEC_IDLE;
        end else if (!timer_running && !any_clear) begin
          next_rxd_state = WEC_IDLE;
        end
      end
      default: next_rxd_state = WEC_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rxd_state <= WEC_IDLE;
      rd_data   <= 8'h00;
    end else begin
      rxd_state <= next_rxd_state;
      rd_data   <= next_rd_data;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_rd_data = rd_data;
  assign o_rxd_low = (rxd_state == WEC_SIGNAL) & i_cond.trx_offline
                   & i_cond.mcu_supply_on;
  assign o_trx_supply_fault_status = supply_fault;
  // sleep needs a wake source and nothing pending
  assign o_sleep_allowed = (trx_en[BIT_TRX_WAKEUP] | (|wake_en)) & ~any_pend;
  // mode logic restores supply and routes reset to standby
  assign o_wake_from_sleep = in_sleep & new_capture;
  // window failure resets at once; timeout only on repeat
  assign o_system_reset = i_src.watchdog_fail
                        & (i_wdog_window_mode | sys_stat[BIT_SYS_WATCHDOG]);
endmodule : wec_event_capture

// ---- logic/wec_pkg.sv ----
package wec_pkg;

  // ---------------------------------------------------------------
  // register addresses (7-bit register space)
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_GLOBAL   = 7'h60;
  localparam logic [6:0] ADDR_SYSTEM   = 7'h61;
  localparam logic [6:0] ADDR_SUPPLY   = 7'h62;
  localparam logic [6:0] ADDR_TRX      = 7'h63;
  localparam logic [6:0] ADDR_WAKEPIN  = 7'h64;
  localparam logic [6:0] ADDR_WAKE_LVL = 7'h4B;
  localparam logic [6:0] ADDR_SYS_EN   = 7'h04;
  localparam logic [6:0] ADDR_SUP_EN   = 7'h1C;
  localparam logic [6:0] ADDR_TRX_EN   = 7'h23;
  localparam logic [6:0] ADDR_WAKE_EN  = 7'h4C;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_SYS_POWER_ON = 4;
  localparam int BIT_SYS_OVERTEMP = 2;
  localparam int BIT_SYS_SERIAL   = 1;
  localparam int BIT_SYS_WATCHDOG = 0;
  localparam int BIT_SUP_SENS_OV  = 2;
  localparam int BIT_SUP_SENS_UV  = 1;
  localparam int BIT_SUP_MCU_UV   = 0;
  localparam int BIT_TRX_FRAME    = 5;
  localparam int BIT_TRX_SILENCE  = 4;
  localparam int BIT_TRX_FAIL     = 1;
  localparam int BIT_TRX_WAKEUP   = 0;
  localparam int BIT_WAKE_RISE    = 1;
  localparam int BIT_WAKE_FALL    = 0;
  localparam int BIT_WAKE_LEVEL   = 1;
  localparam int BIT_GLB_WAKE     = 3;
  localparam int BIT_GLB_TRX      = 2;
  localparam int BIT_GLB_SUPPLY   = 1;
  localparam int BIT_GLB_SYSTEM   = 0;

  // implemented (writable) bits of each status register
  localparam logic [7:0] MASK_SYS  = 8'h17;
  localparam logic [7:0] MASK_SUP  = 8'h07;
  localparam logic [7:0] MASK_TRX  = 8'h33;
  localparam logic [7:0] MASK_WAKE = 8'h03;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ---------------------------------------------------------------
  // modes and timing
  // ---------------------------------------------------------------
  localparam logic [1:0] TRX_MODE_FAIL_DETECT = 2'h1;
  localparam logic [2:0] DEV_MODE_SLEEP   = 3'h1;
  localparam logic [2:0] DEV_MODE_STANDBY = 3'h4;
  localparam logic [2:0] DEV_MODE_NORMAL  = 3'h7;
  localparam int EVENT_DELAY_US  = 380;
  localparam int CLK_MHZ         = 100;
  localparam int EVENT_DELAY_CYC = EVENT_DELAY_US * CLK_MHZ;

  typedef enum logic [2:0] {
    WEC_IDLE    = 3'b001,
    WEC_SIGNAL  = 3'b010,
    WEC_HOLDOFF = 3'b100
  } wec_rxd_state_t;

  // raw event requests from the surrounding device
  typedef struct packed {
    logic bus_wakeup;
    logic overtemp;
    logic serial_fail;
    logic watchdog_fail;
    logic sensor_over;
    logic sensor_under;
    logic mcu_under;
    logic frame_error;
    logic bus_silence;
    logic txd_clamped;
    logic trx_supply_low;
  } wec_src_t;

  // device condition inputs
  typedef struct packed {
    logic       trx_offline;
    logic       mcu_supply_on;
    logic       bus_was_active;
    logic [1:0] transceiver_mode_ctrl;
    logic [2:0] device_mode_code;
  } wec_cond_t;

  // register access strobe from the serial engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] data;
  } wec_reg_req_t;

endpackage : wec_pkg

// ---- logic/wec_sync.sv ----
`timescale 1ns/10ps
// two-stage synchroniser with edge outputs taken off the second stage
module wec_sync (
  input  wire logic i_mclk,
  input  wire logic i_resetn,
  input  wire logic i_async,
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);
  import wec_pkg::*;

  logic meta;
  logic stable;
  logic last;
  logic next_meta;
  logic next_stable;
  logic next_last;

  // -------------------------------------------------------------
  // next values
  // -------------------------------------------------------------
  always_comb begin
    next_meta   = i_async;
    next_stable = meta;
    next_last   = stable;
  end

  // the second stage and its one-cycle delayed copy feed the edge compare
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      last   <= 1'b0;
    end else begin
      meta   <= next_meta;
      stable <= next_stable;
      last   <= next_last;
    end
  end

  assign o_level = stable;
  assign o_rise  = stable & ~last;
  assign o_fall  = ~stable & last;
endmodule : wec_sync

// ---- logic/wec_delay_timer.sv ----
`timescale 1ns/10ps
// one-shot delay counter; restart reloads, stop clears
module wec_delay_timer #(
  parameter int unsigned DELAY_CYC = wec_pkg::EVENT_DELAY_CYC
) (
  input  wire logic i_mclk,
  input  wire logic i_resetn,
  input  wire logic i_start,
  input  wire logic i_stop,
  output logic      o_running,
  output logic      o_expired
);
  import wec_pkg::*;

  logic [23:0] count;
  logic [23:0] next_count;
  logic        expired;
  logic        next_expired;

  // -------------------------------------------------------------
  // count down
  // -------------------------------------------------------------
  always_comb begin
    next_count   = count;
    next_expired = 1'b0;
    if (i_stop) begin
      next_count = 24'h000000;
    end else if (i_start) begin
      next_count = 24'(DELAY_CYC);
    end else if (count != 24'h000000) begin
      next_count = count - 24'h000001;
      next_expired = (count == 24'h000001);
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      count   <= 24'h000000;
      expired <= 1'b0;
    end else begin
      count   <= next_count;
      expired <= next_expired;
    end
  end

  assign o_running = (count != 24'h000000);
  assign o_expired = expired;
endmodule : wec_delay_timer

// ---- sim/wec_host_model.sv ----
`timescale 1ns/10ps
// ---------------------------------------------------------------
// host side: register strobes, read-back and event service
// ---------------------------------------------------------------
module wec_host_model
  import wec_pkg::*;
(
  input  wire logic                  i_mclk,
  input  wire logic [7:0]            i_rd_data,
  output wec_pkg::wec_reg_req_t      o_reg
);
  // idle bus between transfers
  initial o_reg = '0;

  // write one byte; a released bus shows the inverse, not stale values
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    o_reg = '{wr: 1'h1, rd: 1'h0, addr: a, data: d};
    @(negedge i_mclk);
    o_reg = '{wr: 1'h0, rd: 1'h0, addr: ~a, data: ~d};
  endtask : wr

  // read one byte, taken one edge after the strobe
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge i_mclk);
    o_reg = '{wr: 1'h0, rd: 1'h1, addr: a, data: 8'h00};
    @(negedge i_mclk);
    d = i_rd_data;
    o_reg = '{wr: 1'h0, rd: 1'h0, addr: ~a, data: 8'hFF};
  endtask : rd

  // clear only what was seen set, so late arrivals survive
  task automatic service(input logic [6:0] a);
    logic [7:0] v;
    rd(a, v);
    wr(a, v);
  endtask : service
endmodule : wec_host_model

// ---- sim/wec_event_capture_asserts.sv ----
`timescale 1ns/10ps
// ---------------------------------------------------------------
// port-level checks of the event capture block
// ---------------------------------------------------------------
module wec_event_capture_asserts
  import wec_pkg::*;
#(
  parameter int unsigned EVENT_DELAY = 20
) (
  input wire logic                   i_mclk,
  input wire logic                   i_resetn,
  input wire logic                   i_wake_pin,
  input wec_pkg::wec_src_t           i_src,
  input wec_pkg::wec_cond_t          i_cond,
  input wire logic                   i_wdog_window_mode,
  input wire logic                   i_rstn_low,
  input wec_pkg::wec_reg_req_t       i_reg,
  input wire logic [7:0]             o_rd_data,
  input wire logic                   o_rxd_low,
  input wire logic                   o_trx_supply_fault_status,
  input wire logic                   o_sleep_allowed,
  input wire logic                   o_wake_from_sleep,
  input wire logic                   o_system_reset
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  wire logic in_sleep = (i_cond.device_mode_code == DEV_MODE_SLEEP);

  // clear while signalling, then the release window
  sequence s_clear;
    o_rxd_low && i_reg.wr && (i_reg.data != 8'h00) && (i_reg.addr >= ADDR_SYSTEM) && (i_reg.addr <= ADDR_WAKEPIN);
  endsequence
  sequence s_released;
    !o_rxd_low [*8];
  endsequence
  sequence s_rd_global;
    i_reg.rd && (i_reg.addr == ADDR_GLOBAL);
  endsequence
  sequence s_rd_level;
    i_reg.rd && (i_reg.addr == ADDR_WAKE_LVL);
  endsequence

  property p_rxd_release;   s_clear |=> s_released; endproperty
  property p_glb_rsvd;      s_rd_global |=> (o_rd_data[7:4] == 4'h0); endproperty
  property p_lvl_rsvd;      s_rd_level |=> (o_rd_data[7:2] == 6'h00) && !o_rd_data[0]; endproperty
  property p_rxd_gate;      o_rxd_low |-> i_cond.trx_offline && i_cond.mcu_supply_on; endproperty
  property p_wake_mode;     o_wake_from_sleep |-> in_sleep; endproperty
  property p_always_cap;    in_sleep && (i_src.watchdog_fail || i_src.frame_error) |-> o_wake_from_sleep; endproperty
  property p_sleep_skip;    in_sleep && (i_src == 11'h310) |-> !o_wake_from_sleep; endproperty
  property p_rst_window;    i_src.watchdog_fail && i_wdog_window_mode |-> o_system_reset; endproperty
  property p_rst_cause;     !i_src.watchdog_fail |-> !o_system_reset; endproperty

  a_rxd_release: assert property (p_rxd_release) else $error("rxd not released after clear");
  a_glb_rsvd: assert property (p_glb_rsvd) else $error("global reserved bits set");
  a_lvl_rsvd: assert property (p_lvl_rsvd) else $error("level register reserved bits set");
  a_rxd_gate: assert property (p_rxd_gate) else $error("rxd low outside offline with supply");
  a_wake_mode: assert property (p_wake_mode) else $error("wake request outside sleep");
  a_always_cap: assert property (p_always_cap) else $error("always-on event missed in sleep");
  a_sleep_skip: assert property (p_sleep_skip) else $error("sleep-masked event woke device");
  a_rst_window: assert property (p_rst_window) else $error("window failure gave no reset");
  a_rst_cause: assert property (p_rst_cause) else $error("reset without watchdog failure");
endmodule : wec_event_capture_asserts

bind wec_event_capture wec_event_capture_asserts #(.EVENT_DELAY(EVENT_DELAY)) wec_event_capture_asserts_i (
  .i_mclk(i_mclk), .i_resetn(i_resetn), .i_wake_pin(i_wake_pin), .i_src(i_src), .i_cond(i_cond),
  .i_wdog_window_mode(i_wdog_window_mode), .i_rstn_low(i_rstn_low), .i_reg(i_reg), .o_rd_data(o_rd_data),
  .o_rxd_low(o_rxd_low), .o_trx_supply_fault_status(o_trx_supply_fault_status),
  .o_sleep_allowed(o_sleep_allowed), .o_wake_from_sleep(o_wake_from_sleep), .o_system_reset(o_system_reset));

// ---- sim/tb_wake_event_capture_signal.sv ----
`timescale 1ns/10ps
// ---------------------------------------------------------------
// self-checking bench for the event capture block
// ---------------------------------------------------------------
module tb_wake_event_capture_signal;
  import wec_pkg::*;

  logic           mclk        = 1'h0;
  logic           resetn      = 1'h0;
  logic           wake_pin    = 1'h0;
  wec_src_t       src         = '0;
  wec_cond_t      cond        = '{1'h1, 1'h1, 1'h1, TRX_MODE_FAIL_DETECT, DEV_MODE_STANDBY};
  logic           wdog_window = 1'h0;
  logic           rstn_low    = 1'h0;
  wec_reg_req_t   reg_req;
  logic [7:0]     rd_data;
  logic           rxd_low, fault, sleep_ok, wake_sleep, sys_rst;
  logic [7:0]     exp_q[$];
  logic [31:0]    rnd         = 32'h0000E104;
  int             num_errors  = 0;
  int             checks      = 0;

  // short event delay keeps the holdoff visible in a few cycles
  wec_event_capture #(.EVENT_DELAY(20)) wec_event_capture_i (
    .i_mclk(mclk), .i_resetn(resetn), .i_wake_pin(wake_pin), .i_src(src), .i_cond(cond),
    .i_wdog_window_mode(wdog_window), .i_rstn_low(rstn_low), .i_reg(reg_req), .o_rd_data(rd_data),
    .o_rxd_low(rxd_low), .o_trx_supply_fault_status(fault), .o_sleep_allowed(sleep_ok),
    .o_wake_from_sleep(wake_sleep), .o_system_reset(sys_rst));
  wec_host_model wec_host_model_i (.i_mclk(mclk), .i_rd_data(rd_data), .o_reg(reg_req));

  always #5 mclk = ~mclk;

  // read results are compared against the oldest note
  always @(posedge mclk) begin
    if (reg_req.rd === 1'h1) begin
      @(negedge mclk);
      check("rd_data", rd_data, exp_q.pop_front());
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] v;
    exp_q.push_back(e);
    wec_host_model_i.rd(a, v);
  endtask : rd
  task automatic clr(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    wec_host_model_i.service(a);
  endtask : clr
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    wec_host_model_i.wr(a, d);
  endtask : wr
  task automatic fire(input logic [10:0] s);
    @(negedge mclk);
    src = s;
    @(negedge mclk);
    src = '0;
    repeat (2) @(negedge mclk);
  endtask : fire
  // pin edges need two sync stages plus detect before the flag
  task automatic pin(input logic v);
    @(negedge mclk);
    wake_pin = v;
    repeat (6) @(negedge mclk);
  endtask : pin
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xorshift
  task automatic print_verdict();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  // hang guard, far above the few hundred cycles the run needs
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end

  // main sequence
  initial begin
    int n;
    logic [7:0] en;
    repeat (12) @(negedge mclk);
    resetn = 1'h1;
    repeat (3) @(negedge mclk);
    check("rxd", 8'(rxd_low), 8'h01);
    check("sleep_ok", 8'(sleep_ok), 8'h00);
    rd(ADDR_SYSTEM, 8'h10);
    rd(ADDR_GLOBAL, 8'h01);
    rd(ADDR_WAKE_LVL, 8'h00);
    wr(ADDR_SYSTEM, 8'h00);
    rd(ADDR_SYSTEM, 8'h10);
    clr(ADDR_SYSTEM, 8'h10);
    check("rxd", 8'(rxd_low), 8'h00);
    fire(11'h080);
    check("rxd", 8'(rxd_low), 8'h00);
    n = 0;
    while (rxd_low !== 1'h1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    check("rxd", 8'(rxd_low), 8'h01);
    check("holdoff", 8'(n > 12), 8'h01);
    clr(ADDR_SYSTEM, 8'h01);
    // random enables against random system events
    for (int i = 0; i < 4; i++) begin
      rnd = xorshift(rnd);
      en = rnd[7:0] & MASK_SYS;
      wr(ADDR_SYS_EN, en);
      fire({1'h0, rnd[8], rnd[9], rnd[10], 7'h00});
      clr(ADDR_SYSTEM, {5'h00, rnd[8] & en[2], rnd[9] & en[1], rnd[10]});
      rd(ADDR_SYSTEM, 8'h00);
    end
    wr(ADDR_SUP_EN, 8'h07);
    fire(11'h070);
    rd(ADDR_GLOBAL, 8'h02);
    clr(ADDR_SUPPLY, 8'h07);
    wr(ADDR_TRX_EN, 8'h33);
    cond.trx_offline = 1'h0;
    fire(11'h400);
    cond.trx_offline = 1'h1;
    rd(ADDR_TRX, 8'h00);
    fire(11'h40D);
    check("fault", 8'(fault), 8'h01);
    rd(ADDR_GLOBAL, 8'h04);
    clr(ADDR_TRX, 8'h33);
    check("fault", 8'(fault), 8'h00);
    // supply drop outside fail-detect mode, silence on an idle bus
    cond.transceiver_mode_ctrl = 2'h0;
    cond.bus_was_active = 1'h0;
    fire(11'h005);
    rd(ADDR_TRX, 8'h00);
    check("fault", 8'(fault), 8'h00);
    cond.transceiver_mode_ctrl = TRX_MODE_FAIL_DETECT;
    cond.bus_was_active = 1'h1;
    fire(11'h002);
    clr(ADDR_TRX, 8'h02);
    wr(ADDR_TRX_EN, 8'h00);
    // wake pin edges, level validity and the sleep gate
    wr(ADDR_WAKE_EN, 8'h02);
    check("sleep_ok", 8'(sleep_ok), 8'h01);
    pin(1'h1);
    rd(ADDR_WAKE_LVL, 8'h02);
    pin(1'h0);
    rd(ADDR_WAKEPIN, 8'h02);
    wr(ADDR_WAKE_EN, 8'h01);
    clr(ADDR_WAKEPIN, 8'h02);
    pin(1'h1);
    pin(1'h0);
    clr(ADDR_WAKEPIN, 8'h01);
    wr(ADDR_WAKE_EN, 8'h00);
    check("sleep_ok", 8'(sleep_ok), 8'h00);
    pin(1'h1);
    rd(ADDR_WAKE_LVL, 8'h00);
    cond.device_mode_code = DEV_MODE_NORMAL;
    rd(ADDR_WAKE_LVL, 8'h02);
    // sleep: masked diagnostics, wake and watchdog reset
    cond.device_mode_code = DEV_MODE_SLEEP;
    wr(ADDR_SYS_EN, 8'h17);
    fire(11'h310);
    rd(ADDR_SYSTEM, 8'h00);
    rd(ADDR_SUPPLY, 8'h00);
    @(negedge mclk);
    src.watchdog_fail = 1'h1;
    #1 check("wake", 8'(wake_sleep), 8'h01);
    check("rst", 8'(sys_rst), 8'h00);
    @(negedge mclk);
    check("rst", 8'(sys_rst), 8'h01);
    src = '0;
    cond.device_mode_code = DEV_MODE_STANDBY;
    clr(ADDR_SYSTEM, 8'h01);
    wdog_window = 1'h1;
    @(negedge mclk);
    src.watchdog_fail = 1'h1;
    #1 check("rst", 8'(sys_rst), 8'h01);
    @(negedge mclk);
    src = '0;
    wdog_window = 1'h0;
    clr(ADDR_SYSTEM, 8'h01);
    print_verdict();
  end
endmodule : tb_wake_event_capture_signal
